// file: rtl/dcsw_pkg.sv
package dcsw_pkg;
    localparam int CW_W = 16;
    // Control word bit positions
    localparam int CB_PRESET_LO = 0;
    localparam int CB_PRESET_HI = 1;
    localparam int CB_DC_BRAKE_N = 2;
    localparam int CB_COAST_N = 3;
    localparam int CB_QSTOP_N = 4;
    localparam int CB_HOLD_N = 5;
    localparam int CB_START = 6;
    localparam int CB_RESET = 7;
    localparam int CB_JOG = 8;
    localparam int CB_RAMP2 = 9;
    localparam int CB_VALID = 10;
    localparam int CB_RELAY1 = 11;
    localparam int CB_RELAY4 = 12;
    localparam int CB_SETUP_LO = 13;
    localparam int CB_SETUP_HI = 14;
    localparam int CB_REVERSE = 15;
    // Status word bit positions
    localparam int SB_CTRL_READY = 0;
    localparam int SB_DRIVE_READY = 1;
    localparam int SB_ENABLE = 2;
    localparam int SB_TRIP = 3;
    localparam int SB_ERROR = 4;
    localparam int SB_TRIPLOCK = 6;
    localparam int SB_WARNING = 7;
    localparam int SB_AT_REF = 8;
    localparam int SB_BUS_CTRL = 9;
    localparam int SB_IN_LIMIT = 10;
    localparam int SB_RUNNING = 11;
    localparam int SB_OVERTEMP = 12;
    localparam int SB_VOLTAGE = 13;
    localparam int SB_TORQUE = 14;
    localparam int SB_TIMER = 15;
    // Relay function option codes and multi set-up option
    localparam logic [7:0] RELAY1_OPT = 8'h24;
    localparam logic [7:0] RELAY4_OPT = 8'h25;
    localparam logic [3:0] MULTI_SETUP_OPT = 4'h9;
    // Reversing source selections
    localparam logic [1:0] REV_DIGITAL = 2'h0;
    localparam logic [1:0] REV_SERIAL = 2'h1;
    localparam logic [1:0] REV_OR = 2'h2;
    localparam logic [1:0] REV_AND = 2'h3;
    localparam logic signed [15:0] REF_FULL_SCALE = 16'sh4000;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    typedef enum logic [2:0] {
        DCSW_STOP_NONE,
        DCSW_STOP_COAST,
        DCSW_STOP_DC_BRAKE,
        DCSW_STOP_QUICK,
        DCSW_STOP_RAMP
    } dcsw_stop_t;

    // Drive conditions fed in from the rest of the drive
    typedef struct packed {
        logic ctrl_ready;
        logic power_ready;
        logic tripped;
        logic error;
        logic triplocked;
        logic warning;
        logic at_reference;
        logic local_active;
        logic in_limits;
        logic freq_nonzero;
        logic overtemp_halt;
        logic dc_voltage_bad;
        logic current_limit;
        logic thermal_over;
        logic link_fault;
    } dcsw_cond_t;

    // Configuration settings
    typedef struct packed {
        logic [7:0] relay1_func;
        logic [7:0] relay4_func;
        logic [3:0] active_setup;
        logic [1:0] rev_source;
    } dcsw_cfg_t;

    // Decoded commands
    typedef struct packed {
        logic [1:0] preset_sel;
        dcsw_stop_t stop_mode;
        logic       freeze;
        logic       run_enable;
        logic       jog;
        logic       ramp2;
        logic       relay1;
        logic       relay4;
        logic [1:0] setup_sel;
        logic       reverse;
    } dcsw_cmd_t;
endpackage

// file: rtl/dcsw_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01: Bits 1:0 pick one of four presets
// RULE_02: Bit 2 low applies DC brake stop
// RULE_03: Bit 3 low coasts motor immediately
// RULE_04: Bit 4 low quick-stop ramp to standstill
// RULE_05: Bit 5 low freezes present output frequency
// RULE_06: Frozen output stops only by coast/brake/input
// RULE_07: Bit 6 low ramp stop, high allows start
// RULE_08: Trip reset only on bit 7 rise
// RULE_09: Bit 8 high selects jog speed
// RULE_10: Bit 9 selects ramp pair two
// RULE_11: Bit 10 low ignores whole command word
// RULE_12: Bit 11 drives relay one if option 36
// RULE_13: Bit 12 drives relay four if option 37
// RULE_14: Bits 14:13 pick set-up in multi set-up
// RULE_15: Bit 15 reverses only for serial/or/and source
// RULE_16: Status 0 ready unless tripped
// RULE_17: Status 3,4,6,7 fault flags; 5 unused
// RULE_18: Status 8 when speed equals reference
// RULE_19: Status 9 bus control unless local
// RULE_20: Status 10 in limits, 11 running
// RULE_21: Status 12 overtemperature auto-stop halt
// RULE_22: Status 13 voltage, 14 current, 15 timer
// RULE_23: Link fault forces status word zero
// RULE_24: Reference and actual value, 4000h full scale
module dcsw_core (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_ce,
    input  wire logic                      i_cmd_we,
    input  wire logic [15:0]               i_drive_command_word,
    input  wire logic signed [15:0]        i_speed_ref,
    input  wire logic signed [15:0]        i_output_value,
    input  wire logic                      i_din_stop,
    input  wire dcsw_pkg::dcsw_cond_t      i_cond,
    input  wire dcsw_pkg::dcsw_cfg_t       i_cfg,
    output logic [15:0]                    o_drive_state_word,
    output logic signed [15:0]             o_actual_output_value,
    output logic signed [15:0]             o_speed_ref,
    output dcsw_pkg::dcsw_cmd_t            o_cmd,
    output logic                           o_trip_reset
);
    logic [15:0]          cw_q;
    logic                 rst_bit_q;
    dcsw_pkg::dcsw_cmd_t  cmd_d;
    dcsw_pkg::dcsw_cmd_t  cmd_q;
    logic [15:0]          sw_d;
    logic [15:0]          sw_q;
    logic                 trip_rst_q;
    logic signed [15:0]   ref_q;
    logic signed [15:0]   mav_q;
    dcsw_pkg::dcsw_stop_t stop_sel;

    // Invalid words are dropped at the door so the held command stays intact
    wire accept_w = i_cmd_we && i_drive_command_word[dcsw_pkg::CB_VALID]; // [RULE_11]
    wire [15:0] cw_w = accept_w ? i_drive_command_word : cw_q;
    wire rst_rise_w = accept_w && i_drive_command_word[dcsw_pkg::CB_RESET] && !rst_bit_q; // [RULE_08]
    wire freeze_w = !cw_w[dcsw_pkg::CB_HOLD_N]; // [RULE_05]

    // Coast outranks DC brake, which outranks the ramped stops
    always_comb begin
        if (!cw_w[dcsw_pkg::CB_COAST_N]) begin
            stop_sel = dcsw_pkg::DCSW_STOP_COAST; // [RULE_03]
        end else if (!cw_w[dcsw_pkg::CB_DC_BRAKE_N]) begin
            stop_sel = dcsw_pkg::DCSW_STOP_DC_BRAKE; // [RULE_02]
        end else if (i_din_stop) begin
            stop_sel = dcsw_pkg::DCSW_STOP_COAST; // [RULE_06]
        end else if (freeze_w) begin
            stop_sel = dcsw_pkg::DCSW_STOP_NONE; // [RULE_06]
        end else if (!cw_w[dcsw_pkg::CB_QSTOP_N]) begin
            stop_sel = dcsw_pkg::DCSW_STOP_QUICK; // [RULE_04]
        end else if (!cw_w[dcsw_pkg::CB_START]) begin
            stop_sel = dcsw_pkg::DCSW_STOP_RAMP; // [RULE_07]
        end else begin
            stop_sel = dcsw_pkg::DCSW_STOP_NONE;
        end
    end

    wire rev_ok_w = (i_cfg.rev_source == dcsw_pkg::REV_SERIAL) || (i_cfg.rev_source == dcsw_pkg::REV_OR)
                    || (i_cfg.rev_source == dcsw_pkg::REV_AND);
    wire multi_w = (i_cfg.active_setup == dcsw_pkg::MULTI_SETUP_OPT);

    always_comb begin
        cmd_d            = cmd_q;
        cmd_d.preset_sel = {cw_w[dcsw_pkg::CB_PRESET_HI], cw_w[dcsw_pkg::CB_PRESET_LO]}; // [RULE_01]
        cmd_d.stop_mode  = stop_sel;
        cmd_d.freeze     = freeze_w; // [RULE_05]
        cmd_d.run_enable = (stop_sel == dcsw_pkg::DCSW_STOP_NONE) && cw_w[dcsw_pkg::CB_START]; // [RULE_07]
        cmd_d.jog        = cw_w[dcsw_pkg::CB_JOG]; // [RULE_09]
        cmd_d.ramp2      = cw_w[dcsw_pkg::CB_RAMP2]; // [RULE_10]
        cmd_d.relay1     = cw_w[dcsw_pkg::CB_RELAY1] && (i_cfg.relay1_func == dcsw_pkg::RELAY1_OPT); // [RULE_12]
        cmd_d.relay4     = cw_w[dcsw_pkg::CB_RELAY4] && (i_cfg.relay4_func == dcsw_pkg::RELAY4_OPT); // [RULE_13]
        if (multi_w) begin
            cmd_d.setup_sel = {cw_w[dcsw_pkg::CB_SETUP_HI], cw_w[dcsw_pkg::CB_SETUP_LO]}; // [RULE_14]
        end
        cmd_d.reverse    = cw_w[dcsw_pkg::CB_REVERSE] && rev_ok_w; // [RULE_15]
    end

    always_comb begin
        sw_d = dcsw_pkg::ZERO_WORD;
        if (!i_cond.link_fault) begin // [RULE_23]
            sw_d[dcsw_pkg::SB_CTRL_READY]  = i_cond.ctrl_ready && !i_cond.tripped; // [RULE_16]
            sw_d[dcsw_pkg::SB_DRIVE_READY] = i_cond.ctrl_ready && i_cond.power_ready && !i_cond.tripped;
            sw_d[dcsw_pkg::SB_ENABLE]      = cmd_q.stop_mode != dcsw_pkg::DCSW_STOP_COAST;
            sw_d[dcsw_pkg::SB_TRIP]        = i_cond.tripped; // [RULE_17]
            sw_d[dcsw_pkg::SB_ERROR]       = i_cond.error; // [RULE_17]
            sw_d[dcsw_pkg::SB_TRIPLOCK]    = i_cond.triplocked; // [RULE_17]
            sw_d[dcsw_pkg::SB_WARNING]     = i_cond.warning; // [RULE_17]
            sw_d[dcsw_pkg::SB_AT_REF]      = i_cond.at_reference; // [RULE_18]
            sw_d[dcsw_pkg::SB_BUS_CTRL]    = !i_cond.local_active; // [RULE_19]
            sw_d[dcsw_pkg::SB_IN_LIMIT]    = i_cond.in_limits; // [RULE_20]
            sw_d[dcsw_pkg::SB_RUNNING]     = cmd_q.run_enable || i_cond.freq_nonzero; // [RULE_20]
            sw_d[dcsw_pkg::SB_OVERTEMP]    = i_cond.overtemp_halt; // [RULE_21]
            sw_d[dcsw_pkg::SB_VOLTAGE]     = i_cond.dc_voltage_bad; // [RULE_22]
            sw_d[dcsw_pkg::SB_TORQUE]      = i_cond.current_limit; // [RULE_22]
            sw_d[dcsw_pkg::SB_TIMER]       = i_cond.thermal_over; // [RULE_22]
        end
    end

    // Serial commands are refused while local control holds the drive
    wire take_w = !i_cond.local_active; // [RULE_19]

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cw_q       <= dcsw_pkg::ZERO_WORD;
            rst_bit_q  <= 1'b0;
            cmd_q      <= '0;
            sw_q       <= dcsw_pkg::ZERO_WORD;
            trip_rst_q <= 1'b0;
            ref_q      <= '0;
            mav_q      <= '0;
        end else if (i_ce) begin
            if (accept_w && take_w) begin
                cw_q      <= i_drive_command_word;
                rst_bit_q <= i_drive_command_word[dcsw_pkg::CB_RESET];
                ref_q     <= i_speed_ref; // [RULE_24]
            end
            if (take_w) begin
                cmd_q <= cmd_d;
            end
            trip_rst_q <= rst_rise_w && take_w; // [RULE_08]
            sw_q       <= sw_d;
            mav_q      <= i_output_value; // [RULE_24]
        end
    end

    assign o_drive_state_word    = sw_q;
    assign o_actual_output_value = mav_q;
    assign o_speed_ref           = ref_q;
    assign o_cmd                 = cmd_q;
    assign o_trip_reset          = trip_rst_q;

    property p_reset_edge; // [RULE_08]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_trip_reset |-> $past(rst_rise_w) && $past(i_ce);
    endproperty
    a_reset_edge: assert property (p_reset_edge) else $error("trip reset without rising bit"); // [RULE_08]

    property p_no_double_reset; // [RULE_08]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_trip_reset ##1 (i_ce && !accept_w) |=> !o_trip_reset;
    endproperty
    a_no_double_reset: assert property (p_no_double_reset) else $error("reset repeated on steady bit"); // [RULE_08]

    property p_invalid_ignored; // [RULE_11]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_cmd_we && !i_drive_command_word[dcsw_pkg::CB_VALID]) |=> $stable(cw_q);
    endproperty
    a_invalid_ignored: assert property (p_invalid_ignored) else $error("invalid word changed command"); // [RULE_11]

    property p_link_zero; // [RULE_23]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_cond.link_fault) |=> (o_drive_state_word == dcsw_pkg::ZERO_WORD);
    endproperty
    a_link_zero: assert property (p_link_zero) else $error("status not cleared on link fault"); // [RULE_23]

    property p_ready_trip; // [RULE_16]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_cond.tripped) |=> !o_drive_state_word[dcsw_pkg::SB_CTRL_READY];
    endproperty
    a_ready_trip: assert property (p_ready_trip) else $error("ready set while tripped"); // [RULE_16]

    property p_bit5_zero; // [RULE_17]
        @(posedge i_clk) disable iff (!i_rst_n)
        !o_drive_state_word[5];
    endproperty
    a_bit5_zero: assert property (p_bit5_zero) else $error("unused status bit set"); // [RULE_17]

    property p_coast_first; // [RULE_03]
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && !i_cond.local_active && accept_w && !i_drive_command_word[dcsw_pkg::CB_COAST_N])
        |=> (o_cmd.stop_mode == dcsw_pkg::DCSW_STOP_COAST) && !o_cmd.run_enable;
    endproperty
    a_coast_first: assert property (p_coast_first) else $error("coast not applied"); // [RULE_03]

    property p_relay1; // [RULE_12]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_cmd.relay1 |-> $past(i_cfg.relay1_func) == dcsw_pkg::RELAY1_OPT;
    endproperty
    a_relay1: assert property (p_relay1) else $error("relay one without option"); // [RULE_12]

    property p_reverse; // [RULE_15]
        @(posedge i_clk) disable iff (!i_rst_n)
        o_cmd.reverse |-> $past(i_cfg.rev_source) != dcsw_pkg::REV_DIGITAL;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse with digital source"); // [RULE_15]
endmodule
`default_nettype wire

// file: tb/dcsw_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model (
    input  wire logic          i_clk,
    output logic               o_cmd_we,
    output logic [15:0]        o_word,
    output logic signed [15:0] o_ref
);
    initial begin
        o_cmd_we = 1'b0;
        o_word   = 16'h0000;
        o_ref    = 16'sh0000;
    end
    // Idle lines carry the inverse of the last word so a stale copy never passes
    task automatic send(input logic [15:0] w, input logic signed [15:0] r);
        @(negedge i_clk);
        o_cmd_we = 1'b1;
        o_word   = w;
        o_ref    = r;
        @(negedge i_clk);
        o_cmd_we = 1'b0;
        o_word   = ~w;
        o_ref    = ~r;
    endtask
endmodule
`default_nettype wire

// file: tb/dcsw_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dcsw_core_tb_top;
    logic                 i_clk;
    logic                 i_rst_n;
    logic                 i_ce;
    logic                 din_stop;
    logic                 cmd_we;
    logic [15:0]          cmd_word;
    logic signed [15:0]   speed_ref;
    logic signed [15:0]   out_val;
    dcsw_pkg::dcsw_cond_t cond;
    dcsw_pkg::dcsw_cfg_t  cfg;
    logic [15:0]          st_word;
    logic signed [15:0]   act_val;
    logic signed [15:0]   ref_q;
    dcsw_pkg::dcsw_cmd_t  cmd;
    logic                 trip_rst;
    int                   fail_count;
    int                   total_checks;
    int                   pulses;
    localparam logic [15:0] STOP_W [9] = '{16'h047C, 16'h0474, 16'h0478, 16'h046C, 16'h043C,
                                           16'h045C, 16'h044C, 16'h0450, 16'h0458};
    localparam logic [2:0]  STOP_M [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h1, 3'h2};
    localparam logic [14:0] STAT_C [5] = '{15'h4000, 15'h5554, 15'h2AAA, 15'h7FFE, 15'h7FFF};

    dcsw_master_model m (.i_clk(i_clk), .o_cmd_we(cmd_we), .o_word(cmd_word), .o_ref(speed_ref));
    dcsw_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cmd_we(cmd_we),
        .i_drive_command_word(cmd_word), .i_speed_ref(speed_ref), .i_output_value(out_val),
        .i_din_stop(din_stop), .i_cond(cond), .i_cfg(cfg), .o_drive_state_word(st_word),
        .o_actual_output_value(act_val), .o_speed_ref(ref_q), .o_cmd(cmd), .o_trip_reset(trip_rst));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // One-cycle pulses are counted continuously so none is missed inside a send
    always @(negedge i_clk) if (trip_rst === 1'b1) pulses++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    function automatic logic [15:0] exp_st(input dcsw_pkg::dcsw_cond_t c);
        if (c.link_fault) return 16'h0000;
        return {c.thermal_over, c.current_limit, c.dc_voltage_bad, c.overtemp_halt, c.freq_nonzero,
                c.in_limits, ~c.local_active, c.at_reference, c.warning, c.triplocked, 1'b0, c.error,
                c.tripped, 1'b0, c.ctrl_ready & c.power_ready & ~c.tripped, c.ctrl_ready & ~c.tripped};
    endfunction

    task automatic t_stop;
        for (int i = 0; i < 9; i++) begin
            m.send(STOP_W[i], 16'sh0000);
            @(negedge i_clk);
            chk({13'h0, cmd.stop_mode}, {13'h0, STOP_M[i]});
            if (i < 7) chk({15'h0, cmd.freeze}, {15'h0, ~STOP_W[i][5]});
            if (i == 0 || i == 4) chk({15'h0, cmd.run_enable}, {15'h0, i == 0});
        end
        din_stop = 1'b1;
        m.send(16'h044C, 16'sh0000);
        @(negedge i_clk);
        chk({13'h0, cmd.stop_mode}, 16'h0001);
        din_stop = 1'b0;
        $display("test stop done");
    endtask

    task automatic t_fields;
        cfg = {dcsw_pkg::RELAY1_OPT, dcsw_pkg::RELAY4_OPT, dcsw_pkg::MULTI_SETUP_OPT, dcsw_pkg::REV_SERIAL};
        m.send(16'hBF7F, 16'sh4000);
        @(negedge i_clk);
        chk({7'h0, cmd.preset_sel, cmd.jog, cmd.ramp2, cmd.relay1, cmd.relay4, cmd.setup_sel, cmd.reverse},
            16'h01FB);
        chk(ref_q, 16'h4000);
        cfg = {dcsw_pkg::RELAY4_OPT, dcsw_pkg::RELAY1_OPT, 4'h1, dcsw_pkg::REV_DIGITAL};
        m.send(16'hDC7E, 16'shC000);
        @(negedge i_clk);
        chk({7'h0, cmd.preset_sel, cmd.jog, cmd.ramp2, cmd.relay1, cmd.relay4, cmd.setup_sel, cmd.reverse},
            16'h0102);
        chk(ref_q, 16'hC000);
        for (int s = 1; s < 4; s++) begin
            cfg.rev_source = 2'(s);
            m.send(16'h847C, 16'sh0000);
            @(negedge i_clk);
            chk({15'h0, cmd.reverse}, 16'h0001);
        end
        out_val = 16'shC000;
        repeat (2) @(negedge i_clk);
        chk(act_val, 16'hC000);
        $display("test fields done");
    endtask

    task automatic t_valid;
        m.send(16'h047C, 16'sh0000);
        m.send(16'h0074, 16'sh0000);
        @(negedge i_clk);
        chk({13'h0, cmd.stop_mode}, 16'h0000);
        cond.local_active = 1'b1;
        m.send(16'h0474, 16'sh0000);
        repeat (2) @(negedge i_clk);
        chk({13'h0, cmd.stop_mode}, 16'h0000);
        chk({15'h0, st_word[9]}, 16'h0000);
        cond.local_active = 1'b0;
        $display("test valid done");
    endtask

    task automatic t_rst;
        int p0;
        p0 = pulses;
        m.send(16'h047C, 16'sh0000);
        m.send(16'h04FC, 16'sh0000);
        m.send(16'h04FC, 16'sh0000);
        repeat (3) @(negedge i_clk);
        chk(16'(pulses - p0), 16'h0001);
        m.send(16'h047C, 16'sh0000);
        m.send(16'h04FC, 16'sh0000);
        repeat (3) @(negedge i_clk);
        chk(16'(pulses - p0), 16'h0002);
        $display("test trip reset done");
    endtask

    // Enable low must freeze everything; a mid-run reset must clear the held command
    task automatic t_ce;
        i_ce = 1'b0;
        out_val = 16'sh1234;
        m.send(16'h0474, 16'sh0000);
        repeat (2) @(negedge i_clk);
        chk({13'h0, cmd.stop_mode}, 16'h0000);
        chk(act_val, 16'hC000);
        i_ce = 1'b1;
        repeat (2) @(negedge i_clk);
        chk({13'h0, cmd.stop_mode}, 16'h0000);
        chk(act_val, 16'h1234);
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        chk({2'h0, cmd}, 16'h0000);
        chk(st_word, 16'h0000);
        i_rst_n = 1'b1;
        $display("test enable and reset done");
    endtask

    task automatic t_status;
        m.send(16'h0400, 16'sh0000);
        for (int i = 0; i < 5; i++) begin
            cond = STAT_C[i];
            repeat (3) @(negedge i_clk);
            chk(st_word, exp_st(cond));
        end
        $display("test status done");
    endtask

    initial begin
        fail_count = 0;
        total_checks = 0;
        pulses = 0;
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        din_stop = 1'b0;
        out_val = 16'sh0000;
        cond = 15'h4000;
        cfg = '0;
        repeat (10) @(negedge i_clk);
        chk(st_word, 16'h0000);
        chk({2'h0, cmd}, 16'h0000);
        i_rst_n = 1'b1;
        t_stop;
        t_fields;
        t_valid;
        t_rst;
        t_ce;
        t_status;
        summarize;
    end

    initial begin
        repeat (100000) @(posedge i_clk);
        fail_count++;
        summarize;
    end
endmodule
`default_nettype wire
